// >>> inc/general_timer_defs.vh
// register map, field positions, reset values and codes of the general timer
`ifndef GENERAL_TIMER_DEFS_VH
`define GENERAL_TIMER_DEFS_VH

`define GT_ADDR_LOAD        32'hffff0320
`define GT_ADDR_VALUE       32'hffff0324
`define GT_ADDR_CONTROL     32'hffff0328
`define GT_ADDR_CLEAR       32'hffff032c
`define GT_ADDR_CAPTURE     32'hffff0330

`define GT_RST_LOAD         32'h00000000
`define GT_RST_VALUE        32'h0fffffff
`define GT_RST_CONTROL      32'h01000000
`define GT_RST_CAPTURE      32'h00000000

`define GT_CTL_PCOUNT_HI    31
`define GT_CTL_PCOUNT_LO    24
`define GT_CTL_PEN          23
`define GT_CTL_PFLAG        19
`define GT_CTL_ISRC         18
`define GT_CTL_CAPEN        17
`define GT_CTL_CAPSEL_HI    16
`define GT_CTL_CAPSEL_LO    12
`define GT_CTL_CLKSEL_HI    10
`define GT_CTL_CLKSEL_LO    9
`define GT_CTL_UP           8
`define GT_CTL_EN           7
`define GT_CTL_PERIODIC     6
`define GT_CTL_FMT_HI       5
`define GT_CTL_FMT_LO       4
`define GT_CTL_SCALE_HI     3
`define GT_CTL_SCALE_LO     0

`define GT_CLK_LPOSC        2'h0
`define GT_CLK_CORE_DIV     2'h1
`define GT_CLK_CORE         2'h2
`define GT_CLK_PIN          2'h3

`define GT_FMT_BINARY       2'h0
`define GT_FMT_TOD23        2'h2
`define GT_FMT_TOD255       2'h3

`define GT_SCALE_1          4'h0
`define GT_SCALE_16         4'h4
`define GT_SCALE_256        4'h8
`define GT_SCALE_32768      4'hf

`define GT_TOD_MAX_MINSEC   6'h3b
`define GT_TOD_MAX_TICK     7'h7f
`define GT_TOD_MAX_HOUR23   8'h17
`define GT_TOD_MAX_HOUR255  8'hff

`define GT_CAP_SOURCES      18

`endif

// >>> rtl/general_timer_with_capture.v
// 32-bit up/down timer with prescaler, postscaler, time-of-day format and event capture
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_defs.vh"

module general_timer_with_capture #(
	parameter PIN_INDEX = 0
) (
	// clock and reset
	input  wire        ref_clk_in,
	input  wire        reset_in,
	// register port
	input  wire [31:0] addr_in,
	input  wire [31:0] wdata_in,
	input  wire        write_in,
	input  wire        read_in,
	output reg  [31:0] rdata_out,
	// count sources
	input  wire        lp_osc_in,
	input  wire        core_div_tick_in,
	input  wire [1:0]  pin_clk_in,
	input  wire        low_power_in,
	// capture sources
	input  wire [17:0] event_source_in,
	input  wire [17:0] event_enabled_in,
	// interrupt
	output reg         timer_irq_out
);

	reg  [31:0] load_value_r;
	reg  [31:0] count_value_r;
	reg  [31:0] capture_value_r;
	reg  [7:0]  postscale_target_r;
	reg  [7:0]  postscale_count_r;
	reg         postscale_enable_r;
	reg         postscale_compare_flag_r;
	reg         interrupt_source_select_r;
	reg         capture_enable_r;
	reg  [4:0]  capture_event_select_r;
	reg  [1:0]  clock_source_select_r;
	reg         count_direction_r;
	reg         timer_enable_r;
	reg         periodic_mode_r;
	reg  [1:0]  count_format_r;
	reg  [3:0]  prescale_select_r;
	reg  [14:0] prescale_cnt_r;
	reg         lp_osc_prev_r;
	reg         pin_prev_r;
	reg         event_prev_r;

	localparam [31:0] RST_CONTROL = `GT_RST_CONTROL;

	wire        wr_load    = write_in && (addr_in == `GT_ADDR_LOAD);
	wire        wr_control = write_in && (addr_in == `GT_ADDR_CONTROL);
	wire        wr_clear   = write_in && (addr_in == `GT_ADDR_CLEAR);

	// source edge selection; core sources stop in low power, the others run on
	wire        pin_level  = pin_clk_in[PIN_INDEX];
	reg         src_tick;
	always @* begin
		case (clock_source_select_r)
			`GT_CLK_LPOSC:    src_tick = lp_osc_in & ~lp_osc_prev_r;
			`GT_CLK_CORE_DIV: src_tick = core_div_tick_in & ~low_power_in;
			`GT_CLK_CORE:     src_tick = ~low_power_in;
			`GT_CLK_PIN:      src_tick = pin_level & ~pin_prev_r;
			default:          src_tick = 1'b0;
		endcase
	end

	// undefined prescale codes fall back to divide by one
	reg  [14:0] prescale_last;
	always @* begin
		case (prescale_select_r)
			`GT_SCALE_16:    prescale_last = 15'h000f;
			`GT_SCALE_256:   prescale_last = 15'h00ff;
			`GT_SCALE_32768: prescale_last = 15'h7fff;
			default:         prescale_last = 15'h0000;
		endcase
	end

	wire        count_tick = timer_enable_r && src_tick && (prescale_cnt_r == prescale_last);
	wire        tod_mode   = count_format_r[1];
	wire [7:0]  hour_max   = count_format_r[0] ? `GT_TOD_MAX_HOUR255 : `GT_TOD_MAX_HOUR23;

	// full scale and the free-running down-count restart value depend on the format; free-running up counting restarts at zero
	wire [31:0] full_scale = tod_mode ? {hour_max, 2'h0, `GT_TOD_MAX_MINSEC, 2'h0, `GT_TOD_MAX_MINSEC, 1'b0,
	                                     `GT_TOD_MAX_TICK} : 32'hffffffff;
	wire [31:0] terminal   = count_direction_r ? full_scale : 32'h00000000;

	function [31:0] restart_value;
		input        periodic;
		input        up;
		input [31:0] load;
		input [31:0] fs;
		begin
			if (periodic)
				restart_value = load;
			else if (up)
				restart_value = 32'h00000000;
			else
				restart_value = fs;
		end
	endfunction

	// time-of-day step; gap bits are forced to zero
	function [31:0] tod_step;
		input [31:0] v;
		input        up;
		input [7:0]  hmax;
		reg   [7:0]  h;
		reg   [5:0]  m;
		reg   [5:0]  s;
		reg   [6:0]  t;
		begin
			h = v[31:24];
			m = v[21:16];
			s = v[13:8];
			t = v[6:0];
			if (up) begin
				if (t != `GT_TOD_MAX_TICK) begin
					t = t + 7'h01;
				end else begin
					t = 7'h00;
					if (s < `GT_TOD_MAX_MINSEC) begin
						s = s + 6'h01;
					end else begin
						s = 6'h00;
						if (m < `GT_TOD_MAX_MINSEC) begin
							m = m + 6'h01;
						end else begin
							m = 6'h00;
							h = (h >= hmax) ? 8'h00 : h + 8'h01;
						end
					end
				end
			end else begin
				if (t != 7'h00) begin
					t = t - 7'h01;
				end else begin
					t = `GT_TOD_MAX_TICK;
					if (s != 6'h00) begin
						s = (s > `GT_TOD_MAX_MINSEC) ? `GT_TOD_MAX_MINSEC : s - 6'h01;
					end else begin
						s = `GT_TOD_MAX_MINSEC;
						if (m != 6'h00) begin
							m = (m > `GT_TOD_MAX_MINSEC) ? `GT_TOD_MAX_MINSEC : m - 6'h01;
						end else begin
							m = `GT_TOD_MAX_MINSEC;
							h = (h == 8'h00) ? hmax : h - 8'h01;
						end
					end
				end
			end
			tod_step = {h, 2'h0, m, 2'h0, s, 1'b0, t};
		end
	endfunction

	wire [31:0] bin_step  = count_direction_r ? count_value_r + 32'h00000001 : count_value_r - 32'h00000001;
	wire [31:0] next_step = tod_mode ? tod_step(count_value_r, count_direction_r, hour_max) : bin_step;
	// reaching terminal counts as a timeout and the restart value is taken at once,
	// so the period is exactly the number of steps to terminal
	wire        timeout   = count_tick && (next_step == terminal);

	wire [7:0]  post_goal   = (postscale_target_r == 8'h00) ? 8'h01 : postscale_target_r;
	wire        post_match  = timeout && postscale_enable_r && (postscale_count_r + 8'h01 == post_goal);
	wire        irq_event   = interrupt_source_select_r ? post_match : timeout;

	// capture source mux; reserved codes select nothing
	reg         event_level;
	always @* begin
		case (capture_event_select_r)
			5'h01, 5'h02, 5'h03, 5'h04: event_level = event_source_in[capture_event_select_r - 5'h01] &
			                                          event_enabled_in[capture_event_select_r - 5'h01];
			5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11:
			                            event_level = event_source_in[capture_event_select_r] &
			                                          event_enabled_in[capture_event_select_r];
			default:                    event_level = 1'b0;
		endcase
	end
	wire        capture_hit = capture_enable_r && event_level && !event_prev_r;

	// counting path
	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_value_r  <= `GT_RST_VALUE;
			prescale_cnt_r <= 15'h0000;
			lp_osc_prev_r  <= 1'b0;
			pin_prev_r     <= 1'b0;
			event_prev_r   <= 1'b0;
		end else begin
			lp_osc_prev_r <= lp_osc_in;
			pin_prev_r    <= pin_level;
			event_prev_r  <= event_level;
			if (wr_control) begin
				prescale_cnt_r <= 15'h0000;
				// start from the freshly written configuration
				count_value_r  <= restart_value(wdata_in[`GT_CTL_PERIODIC], wdata_in[`GT_CTL_UP], load_value_r,
				                               (wdata_in[`GT_CTL_FMT_HI] ? {(wdata_in[`GT_CTL_FMT_LO] ?
				                               `GT_TOD_MAX_HOUR255 : `GT_TOD_MAX_HOUR23), 2'h0, `GT_TOD_MAX_MINSEC,
				                               2'h0, `GT_TOD_MAX_MINSEC, 1'b0, `GT_TOD_MAX_TICK} : 32'hffffffff));
			end else if (timer_enable_r && src_tick) begin
				prescale_cnt_r <= count_tick ? 15'h0000 : prescale_cnt_r + 15'h0001;
				if (timeout)
					count_value_r <= restart_value(periodic_mode_r, count_direction_r, load_value_r, full_scale);
				else if (count_tick)
					count_value_r <= next_step;
			end
		end
	end

	// register file, postscaler, interrupt and capture
	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			load_value_r              <= `GT_RST_LOAD;
			capture_value_r           <= `GT_RST_CAPTURE;
			postscale_target_r        <= RST_CONTROL[`GT_CTL_PCOUNT_HI:`GT_CTL_PCOUNT_LO];
			postscale_count_r         <= 8'h00;
			postscale_enable_r        <= 1'b0;
			postscale_compare_flag_r  <= 1'b0;
			interrupt_source_select_r <= 1'b0;
			capture_enable_r          <= 1'b0;
			capture_event_select_r    <= 5'h00;
			clock_source_select_r     <= 2'h0;
			count_direction_r         <= 1'b0;
			timer_enable_r            <= 1'b0;
			periodic_mode_r           <= 1'b0;
			count_format_r            <= 2'h0;
			prescale_select_r         <= 4'h0;
			timer_irq_out             <= 1'b0;
			rdata_out                 <= 32'h00000000;
		end else begin
			if (wr_load)
				load_value_r <= wdata_in;
			if (wr_control) begin
				postscale_target_r        <= wdata_in[`GT_CTL_PCOUNT_HI:`GT_CTL_PCOUNT_LO];
				postscale_enable_r        <= wdata_in[`GT_CTL_PEN];
				interrupt_source_select_r <= wdata_in[`GT_CTL_ISRC];
				capture_enable_r          <= wdata_in[`GT_CTL_CAPEN];
				capture_event_select_r    <= wdata_in[`GT_CTL_CAPSEL_HI:`GT_CTL_CAPSEL_LO];
				clock_source_select_r     <= wdata_in[`GT_CTL_CLKSEL_HI:`GT_CTL_CLKSEL_LO];
				count_direction_r         <= wdata_in[`GT_CTL_UP];
				timer_enable_r            <= wdata_in[`GT_CTL_EN];
				periodic_mode_r           <= wdata_in[`GT_CTL_PERIODIC];
				count_format_r            <= wdata_in[`GT_CTL_FMT_HI:`GT_CTL_FMT_LO];
				prescale_select_r         <= wdata_in[`GT_CTL_SCALE_HI:`GT_CTL_SCALE_LO];
				postscale_count_r         <= 8'h00;
			end else if (timeout && postscale_enable_r) begin
				postscale_count_r <= post_match ? 8'h00 : postscale_count_r + 8'h01;
			end
			// a new event in the clearing cycle wins over the clear
			if (post_match)
				postscale_compare_flag_r <= 1'b1;
			else if (wr_clear || wr_control)
				postscale_compare_flag_r <= 1'b0;
			if (irq_event)
				timer_irq_out <= 1'b1;
			else if (wr_clear)
				timer_irq_out <= 1'b0;
			if (capture_hit)
				capture_value_r <= count_value_r;
			// read data stand for the one cycle after the strobe; sampling never disturbs counting
			if (read_in) begin
				case (addr_in)
					`GT_ADDR_LOAD:    rdata_out <= load_value_r;
					`GT_ADDR_VALUE:   rdata_out <= count_value_r;
					`GT_ADDR_CAPTURE: rdata_out <= capture_value_r;
					`GT_ADDR_CONTROL: rdata_out <= {(postscale_enable_r ? postscale_count_r : postscale_target_r),
					                                postscale_enable_r, 3'h0, postscale_compare_flag_r,
					                                interrupt_source_select_r, capture_enable_r,
					                                capture_event_select_r, 1'b0, clock_source_select_r,
					                                count_direction_r, timer_enable_r, periodic_mode_r,
					                                count_format_r, prescale_select_r};
					default:          rdata_out <= 32'h00000000;
				endcase
			end else begin
				rdata_out <= 32'h00000000;
			end
		end
	end

endmodule // general_timer_with_capture
`default_nettype wire

// >>> sim/general_timer_sva.sv
// bound assertions on the general timer register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_defs.vh"
module general_timer_sva (
	// watched ports
	input wire        ref_clk_in,
	input wire        reset_in,
	input wire [31:0] addr_in,
	input wire [31:0] wdata_in,
	input wire        write_in,
	input wire        read_in,
	input wire [31:0] rdata_out,
	input wire        timer_irq_out
);
	logic [31:0] load_r;
	logic        en_r;
	wire         wr_ct = write_in && addr_in == `GT_ADDR_CONTROL;
	wire         wr_cl = write_in && addr_in == `GT_ADDR_CLEAR;
	wire         mapped = addr_in >= `GT_ADDR_LOAD && addr_in <= `GT_ADDR_CAPTURE && addr_in[1:0] == 2'h0;

	// shadow of software state so read data can be predicted without the design's body
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			load_r <= 32'h0;
			en_r <= 1'b0;
		end else begin
			if (write_in && addr_in == `GT_ADDR_LOAD)
				load_r <= wdata_in;
			if (wr_ct)
				en_r <= wdata_in[7];
		end
	end

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	rd_idle_zero_a: assert property (!read_in |=> rdata_out == 32'h0)
		else $error("read data not zero outside a read");
	rd_unmapped_a: assert property (read_in && !mapped |=> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	rd_clear_zero_a: assert property (read_in && addr_in == `GT_ADDR_CLEAR |=> rdata_out == 32'h0)
		else $error("clear register readable");
	rd_load_a: assert property (read_in && addr_in == `GT_ADDR_LOAD |=> rdata_out == $past(load_r))
		else $error("load readback wrong");
	ctl_readback_a: assert property (wr_ct && !wdata_in[23] && wdata_in[31:24] != 8'h0 ##1 !write_in
		##1 read_in && addr_in == `GT_ADDR_CONTROL |=> rdata_out == ($past(wdata_in, 3) & 32'hff87f7ff))
		else $error("control readback wrong");
	stopped_restart_a: assert property (wr_ct && !wdata_in[7] && !wdata_in[5] ##1 !write_in
		##1 read_in && addr_in == `GT_ADDR_VALUE
		|=> rdata_out == ($past(wdata_in[6], 3) ? load_r : {32{!$past(wdata_in[8], 3)}}))
		else $error("restart value wrong");
	irq_sticky_a: assert property (timer_irq_out && !wr_cl |=> timer_irq_out)
		else $error("interrupt dropped without clear");
	irq_needs_run_a: assert property ($rose(timer_irq_out) |-> $past(en_r))
		else $error("interrupt raised while stopped");
endmodule // general_timer_sva

bind general_timer_with_capture general_timer_sva chk (
	.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .timer_irq_out(timer_irq_out)
);
`default_nettype wire

// >>> sim/general_timer_with_capture_tb.sv
// self-checking bench for the general timer with capture
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_defs.vh"
module general_timer_with_capture_tb;
	localparam logic [31:0] LD = `GT_ADDR_LOAD, VL = `GT_ADDR_VALUE, CT = `GT_ADDR_CONTROL;
	localparam logic [31:0] CL = `GT_ADDR_CLEAR, CP = `GT_ADDR_CAPTURE;
	localparam logic [31:0] RUN = 32'hc0, UP = 32'h100, CORE = 32'h400, TOD = 32'h20, PS = 32'h840000;
	logic        ref_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [31:0] addr_in = 32'h0;
	logic [31:0] wdata_in = 32'h0;
	logic        write_in = 1'b0;
	logic        read_in = 1'b0;
	logic        lp_osc_in = 1'b0;
	logic        core_div_tick_in = 1'b0;
	logic [1:0]  pin_clk_in = 2'h0;
	logic        low_power_in = 1'b0;
	logic [17:0] event_source_in = 18'h0;
	logic [17:0] event_enabled_in = 18'h0;
	logic [31:0] rdata_out;
	logic        timer_irq_out;
	logic [31:0] cyc = 32'h0;
	logic [31:0] d, e;
	logic        hit;
	int          failures = 0;
	int          num_checks = 0;

	always #2 ref_clk_in = ~ref_clk_in;
	// slow sources come from one free counter so every tick rate is exact: 8, 16 and 4 cycles
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 32'h1;
		lp_osc_in <= cyc[2];
		pin_clk_in <= {cyc[1], cyc[3]};
		core_div_tick_in <= cyc[1:0] == 2'h3;
	end

	general_timer_with_capture #(.PIN_INDEX(0)) uut (
		.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .lp_osc_in(lp_osc_in),
		.core_div_tick_in(core_div_tick_in), .pin_clk_in(pin_clk_in), .low_power_in(low_power_in),
		.event_source_in(event_source_in), .event_enabled_in(event_enabled_in), .timer_irq_out(timer_irq_out)
	);

	task wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge ref_clk_in);
		write_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge ref_clk_in);
		write_in <= 1'b0;
	endtask
	task rd(input logic [31:0] a);
		@(posedge ref_clk_in);
		read_in <= 1'b1;
		addr_in <= a;
		@(posedge ref_clk_in);
		read_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task end_sim;
		$display("checks=%0d mismatches=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wirq(input logic [31:0] n);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++) begin
			@(posedge ref_clk_in);
			hit = timer_irq_out === 1'b1;
		end
	endtask
	// interval between two interrupts; x of 0 means no interrupt may come within 200 cycles
	task meas(input logic [31:0] l, input logic [31:0] c, input logic [31:0] x);
		logic [31:0] t;
		wr(LD, l);
		wr(CT, c);
		wr(CL, 32'h0);
		wirq(x == 0 ? 32'd200 : 2 * x + 50);
		cmp({31'h0, hit}, {31'h0, x != 0});
		if (x != 0) begin
			if (!hit)
				end_sim;
			t = cyc;
			wr(CL, 32'h0);
			wirq(x + 50);
			cmp(cyc - t, x);
			if (!hit)
				end_sim;
		end
	endtask

	task t_reset;
		logic [31:0] ad [6];
		logic [31:0] ex [6];
		ad = '{LD, VL, CT, CP, CL, 32'hffff0334};
		ex = '{`GT_RST_LOAD, `GT_RST_VALUE, `GT_RST_CONTROL, `GT_RST_CAPTURE, 32'h0, 32'h0};
		wr(VL, 32'h5a5a5a5a);
		wr(CP, 32'ha5a5a5a5);
		for (int i = 0; i < 6; i++) begin
			rd(ad[i]);
			cmp(d, ex[i]);
		end
		$display("t_reset done");
	endtask
	task t_restart;
		wr(LD, 32'h12345678);
		wr(CT, 32'h40);
		rd(VL);
		cmp(d, 32'h12345678);
		wr(CT, 32'h0);
		rd(VL);
		cmp(d, 32'hffffffff);
		wr(CT, UP);
		rd(VL);
		cmp(d, 32'h0);
		wr(CT, 32'h80 | CORE);
		rd(VL);
		e = d;
		rd(VL);
		cmp(e - d, 32'h2);
		cmp({31'h0, e > 32'hfffffff0}, 32'h1);
		wr(CT, 32'h80 | CORE | UP);
		rd(VL);
		e = d;
		rd(VL);
		cmp(d - e, 32'h2);
		$display("t_restart done");
	endtask
	task t_ctl;
		wr(CT, 32'h0547ad44);
		rd(CT);
		cmp(d, 32'h0507a544);
		$display("t_ctl done");
	endtask
	task t_sticky;
		wr(LD, 32'h4);
		wr(CT, RUN | CORE);
		wr(CL, 32'h0);
		wirq(60);
		cmp({31'h0, hit}, 32'h1);
		if (!hit)
			end_sim;
		// stop the timer so only stickiness can keep the interrupt up
		wr(CT, 32'h40);
		repeat (20) @(posedge ref_clk_in);
		cmp({31'h0, timer_irq_out}, 32'h1);
		wr(CL, 32'h3c);
		#1 cmp({31'h0, timer_irq_out}, 32'h0);
		$display("t_sticky done");
	endtask
	task t_prescale;
		logic [3:0] sc [4];
		int         sh [4];
		logic [31:0] l;
		sc = '{4'h0, 4'h4, 4'h8, 4'hf};
		sh = '{0, 4, 8, 15};
		for (int i = 0; i < 4; i++) begin
			l = i == 3 ? 32'h1 : 32'h4;
			meas(l, RUN | CORE | {28'h0, sc[i]}, l << sh[i]);
		end
		meas(32'hfffffff8, RUN | UP | CORE, 32'h7);
		$display("t_prescale done");
	endtask
	task t_post;
		meas(32'h4, RUN | CORE | PS | 32'h03000000, 32'hc);
		rd(CT);
		cmp({31'h0, d[19]}, 32'h1);
		meas(32'h4, RUN | CORE | PS, 32'h4);
		meas(32'h4, RUN | CORE | PS | 32'hff000000, 32'd1020);
		meas(32'h4, RUN | CORE | 32'h03800000, 32'h4);
		$display("t_post done");
	endtask
	task t_tod;
		meas(32'h173b3b7b, RUN | UP | CORE | TOD, 32'h4);
		meas(32'hff3b3b7b, RUN | UP | CORE | 32'h30, 32'h4);
		meas(32'h00000102, RUN | CORE | TOD, 32'd130);
		meas(32'h00010000, RUN | CORE | TOD, 32'd7680);
		meas(32'h00000001, RUN | TOD | 32'h8, 32'd2048);
		$display("t_tod done");
	endtask
	task t_source;
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk_in);
			low_power_in <= p[0];
			meas(32'h4, RUN, 32'h20);
			meas(32'h4, RUN | 32'h600, 32'h40);
			meas(32'h4, RUN | 32'h200, p ? 32'h0 : 32'h10);
			meas(32'h4, RUN | CORE, p ? 32'h0 : 32'h4);
		end
		@(posedge ref_clk_in);
		low_power_in <= 1'b0;
		$display("t_source done");
	endtask
	task t_capture;
		logic        vd;
		logic [17:0] m;
		logic [31:0] prev;
		prev = `GT_RST_CAPTURE;
		for (int c = 0; c < 19; c++) begin
			vd = (c >= 1 && c <= 4) || (c >= 8 && c <= 17);
			m = vd ? 18'h1 << (c < 5 ? c - 1 : c) : 18'h3ffff;
			wr(LD, 32'h00a00000 + c);
			wr(CT, 32'h40 | 32'h20000 | (32'(c) << 12));
			@(posedge ref_clk_in);
			event_source_in <= m;
			repeat (3) @(posedge ref_clk_in);
			rd(CP);
			cmp(d, prev);
			@(posedge ref_clk_in);
			event_enabled_in <= m;
			repeat (3) @(posedge ref_clk_in);
			rd(CP);
			if (vd)
				prev = 32'h00a00000 + c;
			cmp(d, prev);
			@(posedge ref_clk_in);
			event_source_in <= 18'h0;
			event_enabled_in <= 18'h0;
		end
		$display("t_capture done");
	endtask

	initial begin
		repeat (2) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		t_reset;
		t_restart;
		t_ctl;
		t_sticky;
		t_prescale;
		t_post;
		t_tod;
		t_source;
		t_capture;
		end_sim;
	end
endmodule // general_timer_with_capture_tb
`default_nettype wire
